/* hdl/ptm_top.sv */
// Four timer pairs with APB register access, interrupt requests and triggers.
// Assumes APB at CLK_I, pins TCK_I asynchronous, software sequences setup.
//
// Summary of operation
// - Each pair works as one 32-bit timer or two 16-bit timers.
// - Arrangements: two 16-bit timers, one 32-bit timer, one 32-bit counter.
// - Split halves offer every 16-bit mode except asynchronous counting.
// - Each 16-bit timer can be a synchronous timer or synchronous counter.
// - Joined pair raises an interrupt when 32-bit count equals 32-bit period with gating off.
// - Timers keep counting in idle and sleep power modes.
// - Only pair zero drives the capture and compare time base.
// - Pair zero joined gives the first converter its event trigger.
// - Pair one joined gives the second converter its event trigger.
// - Joined pair: even timer is low word, odd timer high word.
// - Joined pair uses odd control only for interrupt enable and priority; even control sets up.
// - Joined pair uses even clock and gate, odd flag, enable, priority.
// - 32-bit period is odd period high word, even period low word.
// - Running 32-bit count lives in count pair, odd register high.
// - Two-bit prescale field selects each timer's prescaler ratio.
// - Source-select bit picks clock; separate gate-enable bit enables gating on the internal clock only.
// - Each interrupt has its own enable bit and three-bit priority field.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module ptm_top (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [7:0] TCK_I,
    output logic [7:0] IRQ_O,
    output logic [23:0] IRQ_PRIO_O,
    output logic ADC1_TRIG_O,
    output logic ADC2_TRIG_O,
    output logic [31:0] TIMEBASE_O
);
    localparam int NT = ptm_pkg::NTMR;
    localparam int NP = ptm_pkg::NPAIR;

    logic [15:0] ctrl_ff [NT];
    logic [15:0] per_ff [NT];
    logic [15:0] cnt_ff [NT];
    logic [15:0] nxt_ctrl [NT];
    logic [15:0] nxt_per [NT];
    logic [15:0] nxt_cnt [NT];
    ptm_pkg::ptm_ctrl_s ctrl_s [NT];
    ptm_pkg::ptm_evt_s evt [NP];
    logic [7:0] flag_ff;
    logic [7:0] nxt_flag;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] irq_ff;
    logic [7:0] nxt_irq;
    logic [23:0] prio_ff;
    logic [23:0] nxt_prio;
    logic [NP-1:0] m32;
    logic [NT-1:0] we_ctrl;
    logic [NT-1:0] we_per;
    logic [NT-1:0] we_cnt;
    logic [7:0] tck_sync;
    logic pready_ff;
    logic slverr_ff;
    logic [31:0] prdata_ff;
    logic adc1_ff;
    logic adc2_ff;

    // APB decode; one wait-free access phase after each setup
    wire setup = PSEL_I & ~PENABLE_I & ~pready_ff;
    wire acc = PSEL_I & PENABLE_I & pready_ff;
    wire wr = acc & PWRITE_I;
    wire [2:0] a_tmr = PADDR_I[6:4];
    wire [1:0] a_reg = PADDR_I[3:2];
    wire a_flag = PADDR_I == ptm_pkg::OFS_FLAG;
    wire a_tmr_ok = ~PADDR_I[7] & (PADDR_I[1:0] == 2'b00) & (a_reg != ptm_pkg::REG_NONE);
    wire a_ok = a_flag | a_tmr_ok;
    wire [15:0] rd_tmr = (a_reg == ptm_pkg::REG_CTRL) ? ctrl_ff[a_tmr]
        : (a_reg == ptm_pkg::REG_PER) ? per_ff[a_tmr] : cnt_ff[a_tmr];
    wire [31:0] rd_val = a_flag ? {24'h000000, flag_ff}
        : a_tmr_ok ? {16'h0000, rd_tmr} : 32'h00000000;

    function automatic logic hit(input logic [2:0] a, input int t, input logic [1:0] r,
            input logic [1:0] want);
        hit = (a == t[2:0]) && (r == want);
    endfunction : hit

    assign flag_clr = (wr & a_flag) ? PWDATA_I[7:0] : 8'h00;

    ptm_sync #(
        .W(NT)
    ) u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i(TCK_I),
        .q_o(tck_sync)
    );

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pair
            ptm_pair u_pair (
                .clk_i(CLK_I),
                .rst_n_i(RST_N_I),
                .ce_i(CE_I),
                .ctrl_lo_i(ctrl_s[2*g]),
                .ctrl_hi_i(ctrl_s[2*g+1]),
                .pin_i(tck_sync[2*g+1:2*g]),
                .evt_o(evt[g])
            );
        end
    endgenerate

    // Register writes and interrupt request shaping
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            ctrl_s[t] = ptm_pkg::ptm_ctrl_s'(ctrl_ff[t]);
            we_ctrl[t] = wr & a_tmr_ok & hit(a_tmr, t, a_reg, ptm_pkg::REG_CTRL);
            we_per[t] = wr & a_tmr_ok & hit(a_tmr, t, a_reg, ptm_pkg::REG_PER);
            we_cnt[t] = wr & a_tmr_ok & hit(a_tmr, t, a_reg, ptm_pkg::REG_CNT);
            nxt_ctrl[t] = we_ctrl[t] ? (PWDATA_I[15:0] & ptm_pkg::CTRL_WMASK) : ctrl_ff[t];
            nxt_per[t] = we_per[t] ? PWDATA_I[15:0] : per_ff[t];
            nxt_irq[t] = flag_ff[t] & ctrl_s[t].timer_irq_enable;
            nxt_prio[3*t +: 3] = ctrl_s[t].timer_irq_priority;
        end
    end

    // Count engine; no power-mode input, so counting continues in idle and sleep
    always_comb begin
        logic [31:0] c32;
        logic [31:0] p32;
        logic [31:0] n32;
        logic gl;
        logic mh;
        int lo;
        int hi;
        c32 = '0;
        p32 = '0;
        n32 = '0;
        gl = 1'b0;
        mh = 1'b0;
        lo = 0;
        hi = 0;
        flag_set = '0;
        m32 = '0;
        for (int p = 0; p < NP; p++) begin
            lo = 2 * p;
            hi = 2 * p + 1;
            if (ctrl_s[lo].pair_join_bit) begin
                c32 = {cnt_ff[hi], cnt_ff[lo]};
                p32 = {per_ff[hi], per_ff[lo]};
                gl = ctrl_s[lo].gate_enable & ~ctrl_s[lo].clock_source_select;
                m32[p] = evt[p].adv[0] & (c32 == p32);
                if (m32[p])
                    n32 = '0;
                else if (evt[p].adv[0])
                    n32 = c32 + 32'h00000001;
                else
                    n32 = c32;
                nxt_cnt[lo] = n32[15:0];
                nxt_cnt[hi] = n32[31:16];
                flag_set[hi] = (m32[p] & ~gl) | evt[p].gfall[0];
            end else begin
                for (int h = 0; h < 2; h++) begin
                    gl = ctrl_s[lo+h].gate_enable & ~ctrl_s[lo+h].clock_source_select;
                    mh = evt[p].adv[h] & (cnt_ff[lo+h] == per_ff[lo+h]);
                    if (mh)
                        nxt_cnt[lo+h] = ptm_pkg::CNT_RST;
                    else if (evt[p].adv[h])
                        nxt_cnt[lo+h] = cnt_ff[lo+h] + ptm_pkg::CNT_ONE;
                    else
                        nxt_cnt[lo+h] = cnt_ff[lo+h];
                    flag_set[lo+h] = (mh & ~gl) | evt[p].gfall[h];
                end
            end
        end
        // Software count write beats the engine in the same cycle
        for (int t = 0; t < NT; t++) begin
            if (we_cnt[t])
                nxt_cnt[t] = PWDATA_I[15:0];
        end
        // Set beats clear so no event is lost
        nxt_flag = (flag_ff & ~flag_clr) | flag_set;
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            for (int t = 0; t < NT; t++) begin
                ctrl_ff[t] <= ptm_pkg::CTRL_RST;
                per_ff[t] <= ptm_pkg::PER_RST;
                cnt_ff[t] <= ptm_pkg::CNT_RST;
            end
            flag_ff <= '0;
            irq_ff <= '0;
            prio_ff <= '0;
            adc1_ff <= 1'b0;
            adc2_ff <= 1'b0;
        end else if (CE_I) begin
            for (int t = 0; t < NT; t++) begin
                ctrl_ff[t] <= nxt_ctrl[t];
                per_ff[t] <= nxt_per[t];
                cnt_ff[t] <= nxt_cnt[t];
            end
            flag_ff <= nxt_flag;
            irq_ff <= nxt_irq;
            prio_ff <= nxt_prio;
            adc1_ff <= m32[0];
            adc2_ff <= m32[1];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pready_ff <= 1'b0;
            slverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (CE_I) begin
            pready_ff <= setup;
            slverr_ff <= setup & ~a_ok;
            prdata_ff <= (setup & ~PWRITE_I) ? rd_val : prdata_ff;
        end
    end

    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = slverr_ff;
    assign IRQ_O = irq_ff;
    assign IRQ_PRIO_O = prio_ff;
    assign ADC1_TRIG_O = adc1_ff;
    assign ADC2_TRIG_O = adc2_ff;
    // Time base taken from pair zero only
    assign TIMEBASE_O = {cnt_ff[1], cnt_ff[0]};

    // Checks on pairs zero and one
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    wire jn0 = ctrl_s[0].pair_join_bit;
    wire nw0 = ~we_cnt[0] & ~we_cnt[1];
    wire gl0 = ctrl_s[0].gate_enable & ~ctrl_s[0].clock_source_select;
    wire eq32 = {cnt_ff[1], cnt_ff[0]} == {per_ff[1], per_ff[0]};
    wire jn1 = ctrl_s[2].pair_join_bit;
    wire gl2 = ctrl_s[2].gate_enable & ~ctrl_s[2].clock_source_select;
    wire [15:0] wdat = PWDATA_I[15:0];

    sequence s_wrap16;
        CE_I && !jn0 && evt[0].adv[0] && (cnt_ff[0] == per_ff[0]) && !gl0 && nw0;
    endsequence
    sequence s_wrap32;
        CE_I && jn0 && evt[0].adv[0] && eq32 && nw0;
    endsequence

    a_wrap_sixteen: assert property (s_wrap16 |=> cnt_ff[0] == ptm_pkg::CNT_RST && flag_ff[0])
        else $error("16-bit wrap did not clear count and set flag");
    a_match_thirtytwo: assert property (s_wrap32 |=> cnt_ff[0] == '0 && cnt_ff[1] == '0)
        else $error("32-bit match did not clear both words");
    a_carry_high: assert property (CE_I && jn0 && evt[0].adv[0] && !eq32 && nw0
        && cnt_ff[0] == ptm_pkg::CNT_MAX |=> cnt_ff[1] == $past(cnt_ff[1]) + ptm_pkg::CNT_ONE)
        else $error("Low word overflow did not carry into high word");
    a_odd_ignored: assert property (CE_I && jn0 && !evt[0].adv[0] && nw0 |=> $stable(cnt_ff[1]))
        else $error("Odd word moved on its own while joined");
    a_adc_one: assert property (s_wrap32 |=> ADC1_TRIG_O && !$past(ADC1_TRIG_O, 2) || ADC1_TRIG_O)
        else $error("First converter trigger missing");
    a_adc_two: assert property (CE_I && m32[1] |=> ADC2_TRIG_O)
        else $error("Second converter trigger missing");
    a_gate_fall: assert property (CE_I && !jn1 && evt[1].gfall[0] |=> flag_ff[2])
        else $error("Gate falling edge did not set flag");
    a_odd_irq: assert property (CE_I && jn0 && flag_ff[1] && ctrl_s[1].timer_irq_enable
        |=> IRQ_O[1] ##1 (IRQ_O[1] || !$past(flag_ff[1])
        || !$past(ctrl_s[1].timer_irq_enable)))
        else $error("Odd timer interrupt not raised for joined pair");
    // Pair one carries the gated scenario, so its gate checks sit there
    a_gate_hold: assert property (CE_I && !jn1 && gl2 && !tck_sync[2] && !we_cnt[2]
        |=> $stable(cnt_ff[2]))
        else $error("Gated count moved while gate input low");
    a_split_hold: assert property (CE_I && !jn0 && !evt[0].adv[1] && nw0
        |=> $stable(cnt_ff[1]))
        else $error("Split odd timer moved without its own advance");
    a_flag_wins: assert property (CE_I && !jn0 && !gl0 && evt[0].adv[0]
        && cnt_ff[0] == per_ff[0] |=> flag_ff[0])
        else $error("Period match flag lost to a clear");
    a_irq_follow: assert property (CE_I |=> IRQ_O[1] == ($past(flag_ff[1])
        && $past(ctrl_s[1].timer_irq_enable)))
        else $error("Odd interrupt request does not follow flag and enable");
    a_prio_copy: assert property (CE_I
        |=> IRQ_PRIO_O[5:3] == $past(ctrl_s[1].timer_irq_priority))
        else $error("Odd timer priority not copied to output");
    a_count_write: assert property (CE_I && we_cnt[1] |=> cnt_ff[1] == $past(wdat))
        else $error("Software count write did not win");
    a_adc1_quiet: assert property (CE_I && !jn0 |=> !ADC1_TRIG_O)
        else $error("First converter triggered while split");
    a_adc2_quiet: assert property (CE_I && !jn1 |=> !ADC2_TRIG_O)
        else $error("Second converter triggered while split");
endmodule : ptm_top

/* hdl/ptm_pkg.sv */
// Shared constants and types for the paired 32-bit timer block.
// Assumes a 32-bit APB master and eight 16-bit timers grouped in four pairs.
package ptm_pkg;
    localparam int NTMR = 8;
    localparam int NPAIR = 4;
    // Byte map: timer t at t*0x10, control +0x0, period +0x4, count +0x8
    localparam logic [7:0] OFS_FLAG = 8'h80;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_PER = 2'h1;
    localparam logic [1:0] REG_CNT = 2'h2;
    localparam logic [1:0] REG_NONE = 2'h3;
    localparam logic [15:0] CTRL_WMASK = 16'hf87a;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PER_RST = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] PSC_LAST_1 = 8'h00;
    localparam logic [7:0] PSC_LAST_8 = 8'h07;
    localparam logic [7:0] PSC_LAST_64 = 8'h3f;
    localparam logic [7:0] PSC_LAST_256 = 8'hff;

    typedef enum logic [1:0] {
        PTM_PSC_1 = 2'b00,
        PTM_PSC_8 = 2'b01,
        PTM_PSC_64 = 2'b10,
        PTM_PSC_256 = 2'b11
    } ptm_psc_e;

    typedef struct packed {
        logic timer_run;
        logic [2:0] timer_irq_priority;
        logic timer_irq_enable;
        logic [3:0] rsv_hi;
        logic gate_enable;
        ptm_psc_e prescale_select;
        logic pair_join_bit;
        logic rsv_b2;
        logic clock_source_select;
        logic rsv_b0;
    } ptm_ctrl_s;

    typedef struct packed {
        logic [1:0] adv;
        logic [1:0] gfall;
    } ptm_evt_s;

    function automatic logic [7:0] psc_last(input ptm_psc_e p);
        unique case (p)
            PTM_PSC_1: psc_last = PSC_LAST_1;
            PTM_PSC_8: psc_last = PSC_LAST_8;
            PTM_PSC_64: psc_last = PSC_LAST_64;
            PTM_PSC_256: psc_last = PSC_LAST_256;
        endcase
    endfunction : psc_last
endpackage : ptm_pkg

/* hdl/ptm_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes once stages two and three agree.
`timescale 1ns/1ps
module ptm_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // First stage feeds only the second
    assign nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
    assign q_o = q_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff <= '0;
        end else if (ce_i) begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end
endmodule : ptm_sync

/* hdl/ptm_pair.sv */
// Prescaler, clock source and gate logic for one timer pair.
// Assumes synchronised pin levels; the owner holds the count registers.
`timescale 1ns/1ps
module ptm_pair (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input ptm_pkg::ptm_ctrl_s ctrl_lo_i,
    input ptm_pkg::ptm_ctrl_s ctrl_hi_i,
    input wire logic [1:0] pin_i,
    output ptm_pkg::ptm_evt_s evt_o
);
    ptm_pkg::ptm_ctrl_s c [2];
    logic [7:0] psc_cnt_ff [2];
    logic [7:0] nxt_psc [2];
    logic [1:0] prev_ff;
    logic [1:0] run;
    logic [1:0] gated;
    logic [1:0] tick;
    logic [1:0] wrap;

    assign c[0] = ctrl_lo_i;
    assign c[1] = ctrl_hi_i;

    always_comb begin
        evt_o = '0;
        for (int h = 0; h < 2; h++) begin
            // Joined pair: odd half is driven from the even half only
            run[h] = c[h].timer_run & ~(h == 1 && ctrl_lo_i.pair_join_bit);
            gated[h] = c[h].gate_enable & ~c[h].clock_source_select;
            tick[h] = (c[h].clock_source_select ? (pin_i[h] & ~prev_ff[h]) : 1'b1)
                & (~gated[h] | pin_i[h]) & run[h];
            wrap[h] = psc_cnt_ff[h] == ptm_pkg::psc_last(c[h].prescale_select);
            evt_o.adv[h] = tick[h] & wrap[h];
            evt_o.gfall[h] = run[h] & gated[h] & prev_ff[h] & ~pin_i[h];
            if (!run[h])
                nxt_psc[h] = '0;
            else if (tick[h])
                nxt_psc[h] = wrap[h] ? '0 : psc_cnt_ff[h] + 8'h01;
            else
                nxt_psc[h] = psc_cnt_ff[h];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            psc_cnt_ff[0] <= '0;
            psc_cnt_ff[1] <= '0;
            prev_ff <= '0;
        end else if (ce_i) begin
            psc_cnt_ff[0] <= nxt_psc[0];
            psc_cnt_ff[1] <= nxt_psc[1];
            prev_ff <= pin_i;
        end
    end
endmodule : ptm_pair

/* verification/ptm_top_tb.sv */
// Self-checking bench for the paired timer block, APB driven.
// Assumes the design files are compiled first; the bench stands in for software.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module ptm_top_tb;
    logic CLK_I;
    logic RST_N_I;
    logic CE_I;
    logic PSEL_I;
    logic PENABLE_I;
    logic PWRITE_I;
    logic [7:0] PADDR_I;
    logic [31:0] PWDATA_I;
    logic [31:0] PRDATA_O;
    logic PREADY_O;
    logic PSLVERR_O;
    logic [7:0] TCK_I;
    logic [7:0] IRQ_O;
    logic [23:0] IRQ_PRIO_O;
    logic ADC1_TRIG_O;
    logic ADC2_TRIG_O;
    logic [31:0] TIMEBASE_O;
    logic [33:0] exp_q[$];
    logic [33:0] note;
    logic [31:0] q;
    logic [31:0] tb0;
    int bad_count = 0;
    int comparisons = 0;
    int trig1 = 0;
    int trig2 = 0;
    int c;
    int k;
    int psc_n[4] = '{1, 8, 64, 256};

    ptm_top i_ptm_top (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
        .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
        .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TCK_I(TCK_I),
        .IRQ_O(IRQ_O), .IRQ_PRIO_O(IRQ_PRIO_O), .ADC1_TRIG_O(ADC1_TRIG_O),
        .ADC2_TRIG_O(ADC2_TRIG_O), .TIMEBASE_O(TIMEBASE_O));

    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end

    function automatic logic [7:0] ra(input int t, input logic [1:0] r);
        ra = 8'(t * 16) + {4'h0, r, 2'b00};
    endfunction : ra

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Request held until the edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic chk, input logic [31:0] ed, input logic ee, output logic [31:0] rd);
        @(posedge CLK_I);
        exp_q.push_back({chk, ee, ed});
        PSEL_I <= 1'b1;
        PENABLE_I <= 1'b0;
        PWRITE_I <= wr;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge CLK_I);
        end while (PREADY_O !== 1'b1);
        rd = PRDATA_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, d, 1'b0, 32'h0, 1'b0, dummy);
    endtask : wr

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] dummy;
        apb(1'b0, a, 32'h0, 1'b1, e, 1'b0, dummy);
    endtask : rdx

    // Cycles until the time base next moves, bounded
    task automatic wait_chg(output int n);
        logic [31:0] last;
        last = TIMEBASE_O;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (TIMEBASE_O === last && n < 600);
    endtask : wait_chg

    // Expected next count worked out from the period, one step per cycle
    task automatic seq(input logic [31:0] per, input int steps);
        int n;
        logic [31:0] prev;
        wait_chg(n);
        prev = TIMEBASE_O;
        repeat (steps) begin
            @(posedge CLK_I);
            `CHK("count", (prev == per) ? 32'h0 : prev + 32'h1, TIMEBASE_O)
            prev = TIMEBASE_O;
        end
    endtask : seq

    always @(posedge CLK_I) begin
        if (PSEL_I && PENABLE_I && PREADY_O === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            `CHK("pslverr", note[32], PSLVERR_O)
            if (note[33]) `CHK("prdata", note[31:0], PRDATA_O)
        end
        if (ADC1_TRIG_O === 1'b1) trig1++;
        if (ADC2_TRIG_O === 1'b1) trig2++;
    end

    // Whole run is about a thousand cycles; this is far beyond it
    initial begin
        repeat (40000) @(posedge CLK_I);
        bad_count++;
        test_done;
    end

    initial begin
        PSEL_I = 1'b0;
        PENABLE_I = 1'b0;
        PWRITE_I = 1'b0;
        PADDR_I = 8'h00;
        PWDATA_I = 32'h0;
        TCK_I = 8'h00;
        CE_I = 1'b1;
        RST_N_I = 1'b0;
        void'($urandom(32'h21a5));
        repeat (20) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            rdx(ra(t, ptm_pkg::REG_CTRL), {16'h0, ptm_pkg::CTRL_RST});
            rdx(ra(t, ptm_pkg::REG_PER), {16'h0, ptm_pkg::PER_RST});
            rdx(ra(t, ptm_pkg::REG_CNT), {16'h0, ptm_pkg::CNT_RST});
        end
        rdx(ptm_pkg::OFS_FLAG, 32'h0);
        apb(1'b0, 8'h8c, 32'h0, 1'b1, 32'h0, 1'b1, q);
        apb(1'b1, 8'h0c, 32'hffff, 1'b0, 32'h0, 1'b1, q);
        // Reserved control bits read back as zero
        wr(ra(7, ptm_pkg::REG_CTRL), 32'hffff);
        rdx(ra(7, ptm_pkg::REG_CTRL), {16'h0, ptm_pkg::CTRL_WMASK});
        `CHK("prio7", 3'h7, IRQ_PRIO_O[23:21])
        wr(ra(7, ptm_pkg::REG_CTRL), 32'h0);
        // Split halves: low word wraps without carry into the odd timer
        wr(ra(0, ptm_pkg::REG_CNT), 32'hfffe);
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h8000);
        seq(32'h0000ffff, 4);
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h0);
        `CHK("irq_masked", 1'b0, IRQ_O[0])
        rdx(ptm_pkg::OFS_FLAG, 32'h01);
        wr(ptm_pkg::OFS_FLAG, 32'hff);
        rdx(ptm_pkg::OFS_FLAG, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(ra(0, ptm_pkg::REG_CTRL), 32'h8000 | (p << 4));
            wait_chg(c);
            wait_chg(c);
            `CHK("psc_gap", psc_n[p], c)
            wr(ra(0, ptm_pkg::REG_CTRL), 32'h0);
        end
        // Pair zero joined; odd control asks for prescale 256 and must be ignored
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h8);
        wr(ra(0, ptm_pkg::REG_PER), 32'h1);
        wr(ra(1, ptm_pkg::REG_PER), 32'h1);
        wr(ra(0, ptm_pkg::REG_CNT), 32'hfffe);
        wr(ra(1, ptm_pkg::REG_CNT), 32'h0);
        wr(ra(1, ptm_pkg::REG_CTRL), 32'h5830);
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h8008);
        seq(32'h00010001, 6);
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h0);
        repeat (2) @(posedge CLK_I);
        `CHK("irq_pair", 2'b10, IRQ_O[1:0])
        `CHK("prio1", 3'h5, IRQ_PRIO_O[5:3])
        `CHK("adc1_trig", 1, trig1)
        `CHK("adc2_idle", 0, trig2)
        rdx(ptm_pkg::OFS_FLAG, 32'h02);
        wr(ptm_pkg::OFS_FLAG, 32'hff);
        // Pair one joined; time base must stay on pair zero
        tb0 = TIMEBASE_O;
        wr(ra(2, ptm_pkg::REG_CTRL), 32'h8);
        wr(ra(2, ptm_pkg::REG_PER), 32'h2);
        wr(ra(3, ptm_pkg::REG_PER), 32'h0);
        wr(ra(2, ptm_pkg::REG_CTRL), 32'h8008);
        repeat (20) @(posedge CLK_I);
        wr(ra(2, ptm_pkg::REG_CTRL), 32'h0);
        `CHK("adc2_trig", 1'b1, trig2 > 0)
        `CHK("adc1_hold", 1, trig1)
        `CHK("timebase", tb0, TIMEBASE_O)
        rdx(ptm_pkg::OFS_FLAG, 32'h08);
        wr(ptm_pkg::OFS_FLAG, 32'hff);
        // Gated accumulation on timer two
        wr(ra(2, ptm_pkg::REG_PER), 32'hffff);
        wr(ra(2, ptm_pkg::REG_CNT), 32'h0);
        wr(ra(2, ptm_pkg::REG_CTRL), 32'h8040);
        k = $urandom_range(10, 3);
        repeat (5) @(posedge CLK_I);
        rdx(ptm_pkg::OFS_FLAG, 32'h0);
        TCK_I[2] <= 1'b1;
        repeat (k) @(posedge CLK_I);
        TCK_I[2] <= 1'b0;
        repeat (10) @(posedge CLK_I);
        apb(1'b0, ra(2, ptm_pkg::REG_CNT), 32'h0, 1'b0, 32'h0, 1'b0, q);
        `CHK("gate_cnt", 32'(k), {16'h0, q[15:0]})
        rdx(ptm_pkg::OFS_FLAG, 32'h04);
        wr(ra(2, ptm_pkg::REG_CTRL), 32'h0);
        // Pin edges as count clock on timer three
        wr(ra(3, ptm_pkg::REG_PER), 32'hffff);
        wr(ra(3, ptm_pkg::REG_CNT), 32'h0);
        wr(ra(3, ptm_pkg::REG_CTRL), 32'h8002);
        k = $urandom_range(6, 2);
        repeat (k) begin
            TCK_I[3] <= 1'b1;
            repeat (4) @(posedge CLK_I);
            TCK_I[3] <= 1'b0;
            repeat (4) @(posedge CLK_I);
        end
        repeat (8) @(posedge CLK_I);
        rdx(ra(3, ptm_pkg::REG_CNT), 32'(k));
        // Clock enable low freezes a running count; no bus traffic meanwhile
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h8000);
        CE_I <= 1'b0;
        @(posedge CLK_I);
        tb0 = TIMEBASE_O;
        repeat (10) @(posedge CLK_I);
        `CHK("ce_hold", tb0, TIMEBASE_O)
        CE_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        `CHK("ce_run", 1'b1, TIMEBASE_O !== tb0)
        wr(ra(0, ptm_pkg::REG_CTRL), 32'h0);
        test_done;
    end
endmodule : ptm_top_tb
